// File: hdl/dts_params.svh
// Offsets, field positions, codes and reset values of the debug trigger block
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DTS_OFS_CONTROL   4'h0
`define DTS_OFS_TRIGGER   4'h4
`define DTS_OFS_STATUS    4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTS_CTL_ON        7
`define DTS_CTL_LAUNCH    6
`define DTS_CTL_TAG       5
`define DTS_CTL_BRK       4
`define DTS_CFG_EXEC      7
`define DTS_CFG_BEGIN     6
`define DTS_ST_AF         7
`define DTS_ST_BF         6
`define DTS_ST_RUN_ACTIVE_FLAG       5

// ----------------------------------------------------------------
// Masks, reset values and sizes
// ----------------------------------------------------------------
`define DTS_CFG_MASK      8'hCF
`define DTS_CTL_RESET     8'h00
`define DTS_CFG_RESET     8'h00
`define DTS_FIFO_FULL     4'h8

// ----------------------------------------------------------------
// Trigger mode codes
// ----------------------------------------------------------------
`define DTS_MODE_A_ONLY   4'h0
`define DTS_MODE_A_OR_B   4'h1
`define DTS_MODE_A_THEN_B 4'h2
`define DTS_MODE_EVT_B    4'h3
`define DTS_MODE_A_EVT_B  4'h4
`define DTS_MODE_A_AND_BD 4'h5
`define DTS_MODE_A_NOT_BD 4'h6
`define DTS_MODE_INSIDE   4'h7
`define DTS_MODE_OUTSIDE  4'h8

`endif

// File: hdl/dts_pkg.sv
// Types shared by the debug trigger and status block
package dts_pkg;

    // ----------------------------------------------------------------
    // Run phases
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT,
        RUN_STORE
    } run_e;

    // ----------------------------------------------------------------
    // Comparator and CPU bus view, one bus cycle per clock
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        fetch;
        logic        exec;
        logic        cof;
        logic        match_a;
        logic        match_b;
        logic        data_match_b;
        logic        below_a;
        logic        above_b;
        logic [15:0] word;
    } cpu_bus_s;

    // ----------------------------------------------------------------
    // Whole block state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       ctl;
        logic [7:0]       cfg;
        run_e             run;
        logic             af;
        logic             bf;
        logic             a_seen;
        logic             pend_a;
        logic             pend_b;
        logic [3:0]       cnt;
        logic [2:0]       wr_ptr;
        logic [2:0]       rd_ptr;
        logic [7:0][15:0] mem;
        logic [15:0]      fifo_word;
        logic             brk;
        logic             brk_tag;
        logic             waitreq;
        logic [31:0]      rdata;
    } state_s;

endpackage

// File: hdl/debug_trigger_and_status.sv
// Debug trigger selection, run status and eight-word trace capture
//
// How it works
// - Trigger configuration always readable; writes ignored while run launch bit set.
// - Trigger configuration bits 5 and 4 read zero, writes ignored.
// - Bit 7 set: match triggers only if opcode at address executes.
// - Bit 6 clear: circular fill until trigger; set: trigger starts storage.
// - Event-only modes ignore bit 6 and always run as begin trace.
// - Mode 0 A alone, 1 A or B, 2 A then B.
// - Mode 3 stores every B event; mode 4 stores B events after A.
// - Mode 5 A address and B data; mode 6 A with B data mismatch.
// - Mode 7 inside A..B, mode 8 outside, modes 9 to 15 never trigger.
// - Match A flag clears at run start, sets on A match while armed.
// - Match B flag clears at run start, sets on B match while armed.
// - Run-active flag mirrors launch bit while module on; set by writing one to the launch bit.
// - Run ends on full FIFO in begin trace, trigger in end trace.
// - Writing zero to launch or module-on bit ends the run at once.
// - Valid count clears at run start, holds words 0 to 8 at end.
// - Valid count does not decrement as FIFO words are read.
// - Status register is read-only; writes change nothing.
// - Launch bit set by software write, cleared when run completes.
// - Module-on bit enables the block; cannot be set while secured.
// - Break request at trigger in end trace, on full in begin trace.
`timescale 1ns/100ps
`default_nettype none
`include "dts_params.svh"

module debug_trigger_and_status (
    input  wire  logic             i_core_clk,
    input  wire  logic             i_rst,
    input  wire  logic             i_ce,
    input  wire  logic [3:0]       i_avs_address,
    input  wire  logic             i_avs_read,
    input  wire  logic             i_avs_write,
    input  wire  logic [31:0]      i_avs_writedata,
    input  wire  logic [3:0]       i_avs_byteenable,
    output logic       [31:0]      o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire  dts_pkg::cpu_bus_s i_bus,
    input  wire  logic             i_secured,
    input  wire  logic             i_fifo_advance,
    output logic       [15:0]      o_fifo_word,
    output logic       [3:0]       o_fifo_valid_words,
    output logic                   o_run_active,
    output logic                   o_break_req,
    output logic                   o_break_tag
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dts_pkg::state_s st;
    dts_pkg::state_s next_st;

    logic       acc;
    logic       done;
    logic       wr_ctl;
    logic       wr_cfg;
    logic [3:0] mode;
    logic       evt_only;
    logic       begin_trace;
    logic       raw_a;
    logic       raw_b;
    logic       hit_a;
    logic       hit_b;
    logic       trig;
    logic       store;
    logic       start;
    logic       stop;
    logic [7:0] stat;

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    always_comb begin
        mode        = st.cfg[3:0];
        evt_only    = (mode == `DTS_MODE_EVT_B) || (mode == `DTS_MODE_A_EVT_B);
        begin_trace = st.cfg[`DTS_CFG_BEGIN] || evt_only;
        if (mode == `DTS_MODE_INSIDE) begin
            raw_a = i_bus.cyc && !i_bus.below_a && !i_bus.above_b;
        end else if (mode == `DTS_MODE_OUTSIDE) begin
            raw_a = i_bus.cyc && (i_bus.below_a || i_bus.above_b);
        end else begin
            raw_a = i_bus.cyc && i_bus.match_a;
        end
        raw_b = i_bus.cyc && i_bus.match_b;
        // Tagged matches wait for the opcode to reach execution
        if (st.cfg[`DTS_CFG_EXEC]) begin
            hit_a = i_bus.exec && st.pend_a;
            hit_b = i_bus.exec && st.pend_b;
        end else begin
            hit_a = raw_a;
            hit_b = raw_b;
        end
        unique case (mode)
            `DTS_MODE_A_ONLY:   trig = hit_a;
            `DTS_MODE_A_OR_B:   trig = hit_a || hit_b;
            `DTS_MODE_A_THEN_B: trig = st.a_seen && hit_b;
            `DTS_MODE_A_AND_BD: trig = hit_a && i_bus.data_match_b;
            `DTS_MODE_A_NOT_BD: trig = hit_a && !i_bus.data_match_b;
            `DTS_MODE_INSIDE,
            `DTS_MODE_OUTSIDE:  trig = hit_a;
            default:            trig = 1'b0;
        endcase
        if (mode == `DTS_MODE_EVT_B) begin
            store = hit_b;
        end else if (mode == `DTS_MODE_A_EVT_B) begin
            store = hit_b && (st.a_seen || hit_a);
        end else begin
            store = i_bus.cof;
        end
    end

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    always_comb begin
        acc    = i_avs_read || i_avs_write;
        done   = acc && !st.waitreq;
        wr_ctl = done && i_avs_write && i_avs_byteenable[0]
                 && (i_avs_address == `DTS_OFS_CONTROL);
        wr_cfg = done && i_avs_write && i_avs_byteenable[0]
                 && (i_avs_address == `DTS_OFS_TRIGGER);
        stat   = 8'h00;
        stat[`DTS_ST_AF]   = st.af;
        stat[`DTS_ST_BF]   = st.bf;
        stat[`DTS_ST_RUN_ACTIVE_FLAG] = st.ctl[`DTS_CTL_LAUNCH] && st.ctl[`DTS_CTL_ON];
        stat[3:0]          = st.cnt;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st     = st;
        next_st.brk = 1'b0;
        start       = 1'b0;
        stop        = 1'b0;

        // Answer one cycle after the request is first seen
        if (acc && st.waitreq) begin
            next_st.waitreq = 1'b0;
            unique case (i_avs_address)
                `DTS_OFS_CONTROL: next_st.rdata = {24'h000000, st.ctl};
                `DTS_OFS_TRIGGER: next_st.rdata = {24'h000000, st.cfg};
                `DTS_OFS_STATUS:  next_st.rdata = {24'h000000, stat};
                default:          next_st.rdata = 32'h00000000;
            endcase
        end
        if (done) begin
            next_st.waitreq = 1'b1;
        end

        // Comparator activity while armed
        if (st.run != dts_pkg::RUN_IDLE) begin
            if (i_bus.fetch) begin
                next_st.pend_a = raw_a;
                next_st.pend_b = raw_b;
            end
            if (hit_a) begin
                next_st.af     = 1'b1;
                next_st.a_seen = 1'b1;
            end
            if (hit_b) begin
                next_st.bf = 1'b1;
            end
        end

        unique case (st.run)
            dts_pkg::RUN_IDLE: begin
            end
            dts_pkg::RUN_WAIT: begin
                if (begin_trace) begin
                    if (trig) begin
                        next_st.run = dts_pkg::RUN_STORE;
                    end
                end else if (trig) begin
                    stop = 1'b1;
                end else if (store) begin
                    // Oldest word is overwritten once eight are held
                    next_st.mem[st.wr_ptr] = i_bus.word;
                    next_st.wr_ptr         = 3'(st.wr_ptr + 3'h1);
                    if (st.cnt != `DTS_FIFO_FULL) begin
                        next_st.cnt = 4'(st.cnt + 4'h1);
                    end
                end
            end
            dts_pkg::RUN_STORE: begin
                if (store) begin
                    next_st.mem[st.wr_ptr] = i_bus.word;
                    next_st.wr_ptr         = 3'(st.wr_ptr + 3'h1);
                    next_st.cnt            = 4'(st.cnt + 4'h1);
                    if (4'(st.cnt + 4'h1) == `DTS_FIFO_FULL) begin
                        stop = 1'b1;
                    end
                end
            end
        endcase

        if (stop) begin
            next_st.ctl[`DTS_CTL_LAUNCH] = 1'b0;
            next_st.run                  = dts_pkg::RUN_IDLE;
            next_st.brk                  = st.ctl[`DTS_CTL_BRK];
            next_st.brk_tag              = st.ctl[`DTS_CTL_TAG];
        end

        // Software writes; status writes fall through untouched
        if (wr_cfg && !st.ctl[`DTS_CTL_LAUNCH]) begin
            next_st.cfg = i_avs_writedata[7:0] & `DTS_CFG_MASK;
        end
        if (wr_ctl) begin
            next_st.ctl[5:0] = i_avs_writedata[5:0];
            next_st.ctl[`DTS_CTL_ON] = i_avs_writedata[`DTS_CTL_ON]
                && (st.ctl[`DTS_CTL_ON] || !i_secured);
            next_st.ctl[`DTS_CTL_LAUNCH] = i_avs_writedata[`DTS_CTL_LAUNCH]
                && next_st.ctl[`DTS_CTL_ON];
            if (!next_st.ctl[`DTS_CTL_LAUNCH]) begin
                next_st.run = dts_pkg::RUN_IDLE;
            // A relaunch written in the completing cycle opens a fresh run
            end else if (!st.ctl[`DTS_CTL_LAUNCH] || stop) begin
                start = 1'b1;
            end
        end

        if (start) begin
            next_st.af     = 1'b0;
            next_st.bf     = 1'b0;
            next_st.cnt    = 4'h0;
            next_st.wr_ptr = 3'h0;
            next_st.a_seen = 1'b0;
            next_st.pend_a = 1'b0;
            next_st.pend_b = 1'b0;
            // Event-only runs enter storage at once, with no trigger wait
            next_st.run = evt_only ? dts_pkg::RUN_STORE : dts_pkg::RUN_WAIT;
        end

        // Readout begins at the oldest captured word
        if (st.run != dts_pkg::RUN_IDLE && next_st.run == dts_pkg::RUN_IDLE) begin
            next_st.rd_ptr = 3'(next_st.wr_ptr - next_st.cnt[2:0]);
        end

        // Reads never touch the count; host keeps its own tally
        if (i_fifo_advance && st.run == dts_pkg::RUN_IDLE) begin
            next_st.fifo_word = st.mem[st.rd_ptr];
            next_st.rd_ptr    = 3'(st.rd_ptr + 3'h1);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st         <= '0;
            st.ctl     <= `DTS_CTL_RESET;
            st.cfg     <= `DTS_CFG_RESET;
            st.waitreq <= 1'b1;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Launch is only ever set with module-on, so it alone is the run flag
    assign o_avs_readdata     = st.rdata;
    assign o_avs_waitrequest  = st.waitreq;
    assign o_fifo_word        = st.fifo_word;
    assign o_fifo_valid_words = st.cnt;
    assign o_run_active       = st.ctl[`DTS_CTL_LAUNCH];
    assign o_break_req        = st.brk;
    assign o_break_tag        = st.brk_tag;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_end_trig;
        i_ce && st.run == dts_pkg::RUN_WAIT && !begin_trace && trig && !wr_ctl;
    endsequence

    sequence s_run_stopped;
        !st.ctl[`DTS_CTL_LAUNCH] && st.run == dts_pkg::RUN_IDLE;
    endsequence

    a_cfg_write_lock: assert property (
        wr_cfg && i_ce && st.ctl[`DTS_CTL_LAUNCH] |=> $stable(st.cfg))
        else $error("trigger config changed while launched");

    a_cfg_zero_bits: assert property (
        st.cfg[5:4] == 2'b00)
        else $error("trigger config bits 5:4 not zero");

    a_run_start_clear: assert property (
        $rose(st.ctl[`DTS_CTL_LAUNCH]) |-> !st.af && !st.bf && st.cnt == 4'h0)
        else $error("flags or count not cleared at run start");

    a_launch_needs_on: assert property (
        st.ctl[`DTS_CTL_LAUNCH] |-> st.ctl[`DTS_CTL_ON])
        else $error("launch set without module on");

    a_secure_block: assert property (
        i_secured && !st.ctl[`DTS_CTL_ON] |=> !st.ctl[`DTS_CTL_ON])
        else $error("module on set while secured");

    a_end_trace_stop: assert property (
        s_end_trig |=> s_run_stopped ##0 (o_break_req == $past(st.ctl[`DTS_CTL_BRK])))
        else $error("end trace did not stop at trigger");

    a_full_stop: assert property (
        st.cnt == `DTS_FIFO_FULL && begin_trace |-> !st.ctl[`DTS_CTL_LAUNCH])
        else $error("begin trace still armed with full fifo");

    a_count_hold: assert property (
        !st.ctl[`DTS_CTL_LAUNCH] ##1 !st.ctl[`DTS_CTL_LAUNCH] |-> $stable(st.cnt))
        else $error("valid count changed outside a run");

    a_abort_stop: assert property (
        wr_ctl && i_ce && !i_avs_writedata[`DTS_CTL_LAUNCH] |=> s_run_stopped)
        else $error("run not aborted by write of zero");

    a_code_none: assert property (
        mode > `DTS_MODE_OUTSIDE |-> !trig)
        else $error("reserved trigger mode fired");

    a_wait_bound: assert property (
        acc && st.waitreq && i_ce |=> !st.waitreq)
        else $error("bus request not answered in one cycle");

    a_exec_gate: assert property (
        st.cfg[`DTS_CFG_EXEC] && !i_bus.exec |-> !hit_a && !hit_b)
        else $error("qualified match fired without execution");

    a_begin_start: assert property (
        i_ce && st.run == dts_pkg::RUN_WAIT && begin_trace && trig && !wr_ctl
        |=> st.run == dts_pkg::RUN_STORE && $stable(st.cnt))
        else $error("begin trace trigger did not start storage");

    a_evt_begin: assert property (
        i_ce && start && evt_only |=> st.run == dts_pkg::RUN_STORE)
        else $error("event-only run not treated as begin trace");

    a_then_order: assert property (
        mode == `DTS_MODE_A_THEN_B && !st.a_seen |-> !trig)
        else $error("A then B fired before A");

    a_evt_count: assert property (
        i_ce && st.run == dts_pkg::RUN_STORE && mode == `DTS_MODE_EVT_B && hit_b && !wr_ctl
        |=> st.cnt != $past(st.cnt))
        else $error("B event not stored");

    a_range_sense: assert property (
        mode == `DTS_MODE_INSIDE && !st.cfg[`DTS_CFG_EXEC]
        && (i_bus.below_a || i_bus.above_b) |-> !trig)
        else $error("inside range fired outside A..B");

    a_match_flags: assert property (
        i_ce && st.run != dts_pkg::RUN_IDLE && !wr_ctl && (hit_a || hit_b)
        |=> (st.af || !$past(hit_a)) && (st.bf || !$past(hit_b)))
        else $error("match flag not set while armed");

    a_full_end: assert property (
        i_ce && st.run == dts_pkg::RUN_STORE && store && st.cnt == 4'h7 && !wr_ctl
        |=> s_run_stopped ##0 st.cnt == `DTS_FIFO_FULL)
        else $error("begin trace did not end at full fifo");

    a_count_range: assert property (
        st.cnt <= `DTS_FIFO_FULL)
        else $error("valid count above eight");

endmodule

`default_nettype wire

// File: verif/cpu_host_model.sv
// CPU bus and debug host model facing the debug trigger block
`timescale 1ns/100ps
`default_nettype none

module cpu_host_model (
    input  wire logic        i_core_clk,
    input  wire logic [8:0]  i_flags,
    input  wire logic [15:0] i_word,
    input  wire logic [3:0]  i_drain,
    input  wire logic        i_drain_go,
    output var dts_pkg::cpu_bus_s o_bus,
    output var logic         o_advance
);
    // ------------------------------------------------------------
    // Bus cycles and host reads
    // ------------------------------------------------------------
    logic [3:0] tally = 4'h0;
    logic [3:0] limit = 4'h0;

    initial o_bus = '0;
    initial o_advance = 1'b0;

    // Outside a bus cycle the word lines wander, so a stale word never looks valid
    always @(posedge i_core_clk) begin
        if (i_flags[8]) begin
            o_bus <= {i_flags, i_word};
        end else begin
            o_bus <= {9'h000, ~o_bus.word};
        end
    end

    // Host pops only as many words as the captured count told it
    always @(posedge i_core_clk) begin
        if (i_drain_go) begin
            limit <= i_drain;
            tally <= 4'h0;
            o_advance <= 1'b0;
        end else if (!o_advance && tally < limit) begin
            o_advance <= 1'b1;
            tally <= tally + 4'h1;
        end else begin
            o_advance <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: verif/debug_trigger_and_status_tb.sv
// Self-checking bench for the debug trigger and status block
`timescale 1ns/100ps
`default_nettype none

module debug_trigger_and_status_tb;
    // ------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------
    localparam logic [8:0] COF = 9'h120;
    localparam logic [8:0] HIT_A = 9'h110;
    localparam logic [8:0] HIT_B = 9'h108;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sec = 1'b0;
    logic [3:0] addr = 4'h0, be = 4'hF, drain = 4'h0;
    logic [31:0] wdata = 32'h00000000, rdata, seed = 32'h00000061;
    logic [8:0] flags = 9'h000, f;
    logic [15:0] word = 16'h0000, fw, w;
    logic go = 1'b0, wreq, adv, brk, tag, run, adv_q = 1'b0, act, as;
    logic [3:0] cnt;
    logic [1:0] ef;
    logic ce = 1'b1;
    dts_pkg::cpu_bus_s bus_v;
    logic [15:0] got[$], exp_q[$];
    int n_errors = 0, n_tests = 0, n_brk = 0, m, nc;

    debug_trigger_and_status DUT (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_bus(bus_v), .i_secured(sec), .i_fifo_advance(adv), .o_fifo_word(fw),
        .o_fifo_valid_words(cnt), .o_run_active(run), .o_break_req(brk), .o_break_tag(tag));
    cpu_host_model host (.i_core_clk(clk), .i_flags(flags), .i_word(word), .i_drain(drain),
        .i_drain_go(go), .o_bus(bus_v), .o_advance(adv));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        adv_q <= adv;
        if (adv_q) got.push_back(fw);
        if (brk === 1'b1) n_brk <= n_brk + 1;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function logic trig(int md, logic [8:0] x, logic seen);
        case (md)
            0: return x[4];
            1: return x[4] | x[3];
            2: return x[3] & seen;
            5: return x[4] & x[2];
            6: return x[4] & !x[2];
            7: return !x[1] & !x[0];
            8: return x[1] | x[0];
            default: return 1'b0;
        endcase
    endfunction

    task give_verdict;
        if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", s, e, g);
            n_errors++;
        end
    endtask

    // Holds the request until waitrequest is sampled low; data taken at that edge
    task acc(input logic wn, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        int k;
        @(posedge clk);
        addr <= a;
        wdata <= {24'h000000, d};
        wr <= wn;
        rd <= !wn;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wreq !== 1'b0 && k < 20);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (k == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task wreg(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    task rchk(input string s, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(s, {8'h00, e}, {8'h00, q});
    endtask

    task drive(input logic [8:0] x, output logic [15:0] wv);
        logic [31:0] r;
        r = rnd();
        wv = r[15:0];
        @(posedge clk);
        flags <= x;
        word <= wv;
    endtask

    task settle;
        drive(9'h000, w);
        repeat (3) @(posedge clk);
    endtask

    task drain_chk;
        got.delete();
        @(posedge clk);
        drain <= cnt;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (24) @(posedge clk);
        chk("words", 16'h0008, 16'(got.size()));
        foreach (exp_q[k]) chk("fifo", exp_q[k], got[k]);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rchk("ctl", 4'h0, 8'h00);
        rchk("cfg", 4'h4, 8'h00);
        rchk("status", 4'h8, 8'h00);
        wreg(4'h4, 8'hFF);
        rchk("cfg", 4'h4, 8'hCF);
        be <= 4'h0;
        wreg(4'h4, 8'h00);
        rchk("cfg", 4'h4, 8'hCF);
        be <= 4'hF;
        sec <= 1'b1;
        wreg(4'h0, 8'h80);
        rchk("ctl", 4'h0, 8'h00);
        sec <= 1'b0;
        wreg(4'h0, 8'hC0);
        rchk("status", 4'h8, 8'h20);
        wreg(4'h4, 8'h00);
        rchk("cfg", 4'h4, 8'hCF);
        wreg(4'h8, 8'hFF);
        rchk("status", 4'h8, 8'h20);
        wreg(4'h0, 8'h40);
        rchk("status", 4'h8, 8'h00);
        rchk("unmapped", 4'hC, 8'h00);
        // Execution-qualified A: a fetch alone must not end the run
        wreg(4'h4, 8'h80);
        wreg(4'h0, 8'hC0);
        drive(9'h190, w);
        settle();
        chk("run", 16'h0001, {15'h0000, run});
        // Clock enable low: the exec pulse is lost and the run stays armed
        ce <= 1'b0;
        drive(9'h140, w);
        settle();
        ce <= 1'b1;
        chk("run", 16'h0001, {15'h0000, run});
        drive(9'h140, w);
        settle();
        chk("run", 16'h0000, {15'h0000, run});
        // End trace: ten stores into eight words, then A ends the run
        wreg(4'h0, 8'h80);
        wreg(4'h4, 8'h00);
        wreg(4'h0, 8'hD0);
        exp_q.delete();
        repeat (10) begin
            drive(COF, w);
            exp_q.push_back(w);
            if (exp_q.size() > 8) void'(exp_q.pop_front());
        end
        drive(HIT_A, w);
        settle();
        rchk("status", 4'h8, 8'h88);
        drain_chk();
        rchk("status", 4'h8, 8'h88);
        chk("brk", 16'h0001, 16'(n_brk));
        // Begin trace: stores before B are dropped, eighth store ends the run
        wreg(4'h4, 8'h41);
        wreg(4'h0, 8'hF0);
        drive(COF, w);
        drive(HIT_B, w);
        exp_q.delete();
        repeat (8) begin
            drive(COF, w);
            exp_q.push_back(w);
        end
        settle();
        rchk("status", 4'h8, 8'h48);
        drain_chk();
        chk("brk", 16'h0002, 16'(n_brk));
        chk("tag", 16'h0001, {15'h0000, tag});
        // Every mode code with random comparator outcomes, end trace selected
        for (int i = 0; i < 32; i++) begin
            m = i % 16;
            act = 1'b1;
            as = 1'b0;
            ef = 2'b00;
            nc = 0;
            wreg(4'h4, 8'(m));
            wreg(4'h0, 8'hC0);
            repeat (3) begin
                f = {4'h8, 5'(rnd())};
                if (f[4]) f[3] = 1'b0;
                // Flags follow matches while armed, the trigger cycle included
                if (act) begin
                    ef[1] |= (m == 7 || m == 8) ? trig(m, f, as) : f[4];
                    ef[0] |= f[3];
                    if (f[3] && (m == 3 || (m == 4 && as))) nc++;
                    if (trig(m, f, as)) act = 1'b0;
                end
                as |= f[4];
                drive(f, w);
            end
            settle();
            rchk("status", 4'h8, {ef, act, 1'b0, 4'(nc)});
            chk("run", {15'h0000, act}, {15'h0000, run});
            wreg(4'h0, 8'h80);
        end
        give_verdict();
    end
endmodule

`default_nettype wire
